// ### logic/bpg_top.sv
// Purpose: APB register-mapped byte parity generator
// Assumes: APB4 master on pclk, presetn asynchronous active low
// Notes: every access takes one wait state; unmapped words answer pslverr
//        operand and result bits hold no reset value
//        byte address is four times the word index
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "bpg_defines.svh"
module bpg_top #(
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import bpg_pkg::*;

   localparam int IDX_W = ADDR_W - 2;
   localparam logic [IDX_W-1:0] IDX_OPERAND = IDX_W'(`BPG_IDX_OPERAND);
   localparam logic [IDX_W-1:0] IDX_CTRL = IDX_W'(`BPG_IDX_CTRL);

   // refuse an address too narrow for the word indexes
   if (ADDR_W < `BPG_IDX_W + 2 || ADDR_W > 32) begin : g_bad_addr_w
      $error("bpg_top: ADDR_W must lie between 10 and 32");
   end

   // the operand must fit the low byte lane
   if (`BPG_OPERAND_LSB + `BPG_OPERAND_W > 8) begin : g_bad_lane
      $error("bpg_top: operand does not fit its byte lane");
   end

   // handshake
   bpg_apb_e state;
   bpg_apb_e next_state;
   logic next_pready;
   logic next_pslverr;
   logic [31:0] next_prdata;
   bpg_answer_s next_answer;

   // register storage
   logic [`BPG_OPERAND_W-1:0] operand;
   logic [`BPG_OPERAND_W-1:0] next_operand;
   logic odd_sel;
   logic next_odd_sel;
   logic result;
   logic calc_parity;
   bpg_regs_s regs;

   // one word index against one register index
   function automatic logic idx_hit(input logic [IDX_W-1:0] idx,
                                    input logic [IDX_W-1:0] target);
      idx_hit = (idx == target);
   endfunction

   // a completed write reaching one byte lane of one register
   function automatic logic lane_write(input logic done,
                                       input logic hit,
                                       input logic strobe);
      lane_write = done & hit & strobe;
   endfunction

   // read data assembly; reserved bits read zero
   function automatic logic [31:0] read_word(input logic op_hit,
                                             input logic ctl_hit,
                                             input bpg_regs_s r);
      logic [31:0] w;
      w = `BPG_DATA_ZERO;
      if (op_hit) begin
         w[`BPG_OPERAND_LSB +: `BPG_OPERAND_W] = r.operand;
      end
      if (ctl_hit) begin
         w[`BPG_BIT_RESULT] = r.result;
         w[`BPG_BIT_SEL] = r.odd_sel;
      end
      read_word = w;
   endfunction

   // word index decode; byte bits of the address are ignored
   wire logic [IDX_W-1:0] word_idx = paddr[ADDR_W-1:2];
   wire logic hit_operand = idx_hit(word_idx, IDX_OPERAND);
   wire logic hit_ctrl = idx_hit(word_idx, IDX_CTRL);
   wire logic hit_any = hit_operand | hit_ctrl;
   wire logic read_req = ~pwrite & hit_any;

   // first access cycle starts the wait state, the second edge after it completes
   wire logic in_access = psel & penable;
   wire logic idle = (state == BPG_IDLE);
   wire logic access_start = in_access & idle;
   wire logic complete = in_access & pready;
   wire logic wr_done = complete & pwrite & ~pslverr;

   // byte lanes and write data fields
   wire logic strb_operand = pstrb[`BPG_LANE_OPERAND];
   wire logic strb_ctrl = pstrb[`BPG_LANE_CTRL];
   wire logic wr_operand = lane_write(wr_done, hit_operand, strb_operand);
   wire logic wr_ctrl = lane_write(wr_done, hit_ctrl, strb_ctrl);
   wire logic [`BPG_OPERAND_W-1:0] wdata_operand =
      pwdata[`BPG_OPERAND_LSB +: `BPG_OPERAND_W];
   wire logic wdata_sel = pwdata[`BPG_BIT_SEL];

   // register next values; the result bit takes no write
   assign next_operand = wr_operand ? wdata_operand : operand;
   assign next_odd_sel = wr_ctrl ? wdata_sel : odd_sel;

   // handshake state: idle until the first access cycle, then answer
   always_comb begin
      next_state = state;
      unique case (state)
         BPG_IDLE: begin
            if (in_access) begin
               next_state = BPG_ANSWER;
            end
         end
         BPG_ANSWER: begin
            next_state = BPG_IDLE;
         end
      endcase
   end

   // registers travel together as one struct
   assign regs = '{
      operand: operand,
      odd_sel: odd_sel,
      result: result
   };

   // answer of the access phase
   wire logic [31:0] read_data = read_word(hit_operand, hit_ctrl, regs);
   assign next_answer = '{
      data: read_req ? read_data : `BPG_DATA_ZERO,
      err: ~hit_any
   };

   // answer stands one cycle; data reads zero outside it
   assign next_pready = access_start;
   assign next_pslverr = access_start & next_answer.err;
   assign next_prdata = access_start ? next_answer.data : `BPG_DATA_ZERO;

   bpg_parity_calc #(
      .WIDTH(`BPG_OPERAND_W)
   ) u_calc (
      .operand(operand),
      .odd_sel(odd_sel),
      .parity(calc_parity)
   );

   // handshake state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= BPG_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ready pulse, high in the second access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= `BPG_FLAG_CLEAR;
      end else begin
         pready <= next_pready;
      end
   end

   // error pulse beside ready for an unmapped word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= `BPG_FLAG_CLEAR;
      end else begin
         pslverr <= next_pslverr;
      end
   end

   // read data, zero outside the answer cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= `BPG_DATA_ZERO;
      end else begin
         prdata <= next_prdata;
      end
   end

   // select bit has a reset value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         odd_sel <= `BPG_SEL_RESET;
      end else begin
         odd_sel <= next_odd_sel;
      end
   end

   // operand holds no reset value
   always_ff @(posedge pclk) begin
      operand <= next_operand;
   end

   // result follows operand and select one clock later
   always_ff @(posedge pclk) begin
      result <= calc_parity;
   end
endmodule
`default_nettype wire

// ### logic/bpg_defines.svh
// Purpose: constants of the byte parity generator
// Assumes: included by bare name
// Notes: offsets are word indexes; byte address is four times the index
`ifndef BPG_DEFINES_SVH
`define BPG_DEFINES_SVH

`define BPG_IDX_OPERAND 8'h18
`define BPG_IDX_CTRL 8'h19
`define BPG_IDX_W 8
`define BPG_OPERAND_W 8
`define BPG_OPERAND_LSB 0
`define BPG_BIT_SEL 8
`define BPG_BIT_RESULT 15
`define BPG_SEL_RESET 1'b0
`define BPG_SEL_ODD 1'b1
`define BPG_LANE_OPERAND 0
`define BPG_LANE_CTRL 1
`define BPG_DATA_ZERO 32'h0000_0000
`define BPG_FLAG_CLEAR 1'b0

`endif

// ### logic/bpg_pkg.sv
// Purpose: types of the byte parity generator
// Assumes: bpg_defines.svh holds the numbers
// Notes: none
`include "bpg_defines.svh"
package bpg_pkg;
   typedef enum logic {
      BPG_IDLE,
      BPG_ANSWER
   } bpg_apb_e;

   typedef struct packed {
      logic [`BPG_OPERAND_W-1:0] operand;
      logic odd_sel;
      logic result;
   } bpg_regs_s;

   typedef struct packed {
      logic [31:0] data;
      logic err;
   } bpg_answer_s;
endpackage

// ### logic/bpg_parity_calc.sv
// Purpose: parity of one operand, odd or even
// Assumes: combinational, driven from registers on pclk
// Notes: result goes to a flop in the top
`timescale 1ns/10ps
`default_nettype none
`include "bpg_defines.svh"
module bpg_parity_calc #(
   parameter int WIDTH = `BPG_OPERAND_W
) (
   input wire logic [WIDTH-1:0] operand,
   input wire logic odd_sel,
   output logic parity
);
   import bpg_pkg::*;

   // refuse a width with no bits
   if (WIDTH < 1) begin : g_bad_width
      $error("bpg_parity_calc: WIDTH must be at least 1");
   end

   // ones count odd gives 1 for even parity, 0 for odd parity
   function automatic logic calc(input logic [WIDTH-1:0] d, input logic odd);
      calc = (^d) ^ (odd == `BPG_SEL_ODD);
   endfunction

   assign parity = calc(operand, odd_sel);
endmodule
`default_nettype wire

// ### logic/bpg_top_unused_note_placeholder.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ### testbench/bpg_monitor.sv
// Purpose: port checks of the parity block
// Assumes: bound to bpg_top
// Notes: mirrors the written operand and select
`timescale 1ns/10ps
`default_nettype none
module bpg_monitor #(
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire done = psel & penable & pready;
   wire a_op = paddr[ADDR_W-1:2] == (ADDR_W-2)'(8'h18);
   wire a_ct = paddr[ADDR_W-1:2] == (ADDR_W-2)'(8'h19);
   wire rd_op = done & ~pwrite & a_op;
   wire rd_ct = done & ~pwrite & a_ct;
   logic [7:0] op;
   logic sel;
   logic opv;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel <= 1'b0;
         opv <= 1'b0;
      end else if (done & pwrite) begin
         if (a_op & pstrb[0]) op <= pwdata[7:0];
         if (a_op & pstrb[0]) opv <= 1'b1;
         if (a_ct & pstrb[1]) sel <= pwdata[8];
      end
   end
   AST_RDY: assert property (psel & penable & ~pready |=> pready)
      else $error("late answer");
   AST_OPRD: assert property (rd_op & opv |-> prdata[7:0] == op)
      else $error("operand lost");
   AST_OPHI: assert property (rd_op |-> prdata[31:8] == 24'h0)
      else $error("operand high bits");
   AST_MAP: assert property (rd_ct |-> ~|(prdata & 32'hFFFF7EFF))
      else $error("control unused bits");
   AST_SEL: assert property (rd_ct |-> prdata[8] == sel)
      else $error("select wrong");
   AST_ODD: assert property (rd_ct & opv & sel |->
      prdata[15] == ~^op)
      else $error("odd parity wrong");
   AST_EVEN: assert property (rd_ct & opv & ~sel |->
      prdata[15] == ^op)
      else $error("even parity wrong");
endmodule
bind bpg_top bpg_monitor #(.ADDR_W(ADDR_W)) i_mon (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr);
`default_nettype wire

// ### testbench/testbench.sv
// Purpose: random and corner tests of the parity block
// Assumes: one wait state apb slave
// Notes: control register expectations come from ctl_exp
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import bpg_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, d;
   logic [3:0] pstrb = 0;
   logic pready, pslverr;
   logic [7:0] o;
   logic [7:0] cc [4] = '{8'h00, 8'h55, 8'h80, 8'hAB};
   int error_cnt = 0, checked = 0;
   initial forever #5 pclk = ~pclk;
   bpg_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .prdata, .pready, .pslverr);
   function automatic logic [31:0] ctl_exp(logic [7:0] v, logic s);
      return {16'h0000, ^v ^ s, 6'h00, s, 8'h00};
   endfunction
   task print_verdict;
      $display("checked %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task xfer(logic w, logic [11:0] a, logic [31:0] v, logic [3:0] s);
      int n;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, v, s};
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         error_cnt++;
         print_verdict;
      end
      psel <= 0;
      penable <= 0;
   endtask
   task rd(logic [11:0] a, logic [31:0] x, logic xe);
      xfer(0, a, 0, 0);
      checked++;
      if ({prdata, pslverr} !== {x, xe}) begin
         error_cnt++;
         $display("mismatch t=%0t got %h exp %h", $time, prdata, x);
      end
   endtask
   initial begin
      void'($urandom(3));
      repeat (8) @(posedge pclk);
      presetn <= 1;
      xfer(1, 12'h060, 0, 4'h1);
      rd(12'h064, ctl_exp(0, 0), 0);
      for (int i = 0; i < 24; i++) begin
         o = i < 8 ? cc[i / 2] : 8'($urandom);
         d = $urandom;
         d[8] = i[0];
         xfer(1, 12'h064, d, 4'h2);
         xfer(1, 12'h060, {24'($urandom), o}, 4'hF);
         rd(12'h064, ctl_exp(o, i[0]), 0);
         rd(12'h060, {24'h0, o}, 0);
         $display("test %0d done", i);
      end
      presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      rd(12'h064, ctl_exp(o, 0), 0);
      xfer(1, 12'h060, {24'h0, ~o}, 4'h0);
      rd(12'h060, {24'h0, o}, 0);
      rd(12'h068, 0, 1);
      print_verdict;
   end
endmodule
`default_nettype wire
